// [design/rtc_value_window.sv]
// Purpose: Clock/calendar control, status and windowed value access
// Assumes: APB master on clk_sys; ce freezes all state
// Notes:   Value halves are byte-wide words; the pointer walks down on high accesses
`timescale 1ns/10ps
module rtc_value_window #(
    parameter int SEC_CYCLES       = rtc_pkg::SEC_CYCLES,
    parameter int SYNC_LEAD_CYCLES = rtc_pkg::SYNC_LEAD_CYCLES
) (
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    input  wire logic                       ce,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [rtc_pkg::ADDR_W-1:0] paddr,
    input  wire logic [rtc_pkg::DATA_W-1:0] pwdata,
    output logic      [rtc_pkg::DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    output logic                            clock_out,
    output logic                            clock_out_oe_n,
    output logic                            irq
);
    import rtc_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic               enable;         // module_enable
        logic               wren;           // value_write_enable
        logic               oe;             // clock_output_enable
        logic [1:0]         ptr;            // value_window_pointer
        logic               sync;           // read_sync_status
        logic               half_second_status;        // half_second_status
        logic [PRESC_W-1:0] presc;          // Second timebase count
        logic [IRQ_W-1:0]   irq_status;     // Sticky events
        logic [IRQ_W-1:0]   irq_mask;       // Event mask
        logic               irq;            // Interrupt line
        logic               clock_out;      // Clock output level
        logic               clock_out_oe_n; // Clock output enable, low drives
        logic [DATA_W-1:0]  prdata;         // Read data
        logic               pready;         // Access phase answer
        logic               pslverr;        // Unmapped address
    } rtc_state_t;

    rtc_state_t          st;                 // Registered state
    rtc_state_t          next_st;            // Next state
    logic                setup_c;            // APB setup cycle
    logic                access_c;           // APB completing access
    logic                tick;               // Second rollover
    logic [NFIELD-1:0]   field_load;         // Field load strobes
    logic [NFIELD-1:0]   carry_in;           // Field carry inputs
    logic [NFIELD-1:0]   carry_out;          // Field carry outputs
    logic [7:0]          fv [NFIELD];        // Field values
    logic [7:0]          load_value;         // Byte to load
    logic [7:0]          hi_byte;            // Upper window byte
    logic [7:0]          lo_byte;            // Lower window byte
    logic [2:0]          hi_idx;             // Upper field index
    logic [2:0]          lo_idx;             // Lower field index
    logic                hi_valid;           // Upper field exists
    logic [DATA_W-1:0]   rd;                 // Read mux
    logic [IRQ_W-1:0]    irq_set;            // Events this cycle
    logic [IRQ_W-1:0]    irq_clr;            // Write-one clears

    // Setup opens a transfer; a completing access needs the registered answer
    assign setup_c  = psel && !penable;
    assign access_c = psel && penable && st.pready;

    // ----------------------------------------
    // Time fields
    // ----------------------------------------
    // Each field carries from its source field; seconds from the timebase
    genvar gi;
    generate
        for (gi = 0; gi < NFIELD; gi++) begin : g_field
            if (gi == F_SEC) begin : g_src
                assign carry_in[gi] = tick;
            end else begin : g_src
                assign carry_in[gi] = carry_out[FSRC[gi]];
            end
            field_counter #(
                .MIN_VAL (FMIN[gi]),
                .MAX_VAL (FMAX[gi])
            ) u_field (
                .clk_sys    (clk_sys),
                .reset_n    (reset_n),
                .ce         (ce),
                .carry_in   (carry_in[gi]),
                .load       (field_load[gi]),
                .load_value (load_value),
                .value      (fv[gi]),
                .carry_out  (carry_out[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st    = st;
        tick       = 1'b0;
        field_load = '0;
        load_value = 8'h00;
        rd         = '0;
        irq_set    = '0;
        irq_clr    = '0;
        // Window selection by pointer
        case (st.ptr)
            WIN_SEC_MIN: begin
                hi_idx = 3'(F_MIN);
                lo_idx = 3'(F_SEC);
            end
            WIN_HOUR_WDAY: begin
                hi_idx = 3'(F_WDAY);
                lo_idx = 3'(F_HOUR);
            end
            WIN_DAY_MONTH: begin
                hi_idx = 3'(F_MONTH);
                lo_idx = 3'(F_DAY);
            end
            default: begin
                hi_idx = 3'(F_YEAR);
                lo_idx = 3'(F_YEAR);
            end
        endcase
        hi_valid = (st.ptr != WIN_YEAR);
        // Reserved upper slot reads zero
        hi_byte  = hi_valid ? fv[hi_idx] : 8'h00;
        lo_byte  = fv[lo_idx];
        if (ce) begin
            // Timebase runs only while enabled
            if (st.enable) begin
                if (st.presc == PRESC_W'(SEC_CYCLES - 1)) begin
                    tick          = 1'b1;
                    next_st.presc = '0;
                end else begin
                    next_st.presc = st.presc + 1'b1;
                end
            end
            // Setup: latch read data so it is stable in access phase
            if (setup_c) begin
                next_st.pready  = 1'b1;
                next_st.pslverr = 1'b0;
                if (paddr == OFF_CTRL) begin
                    rd[B_EN]            = st.enable;
                    rd[B_UNIMP]         = 1'b0;
                    rd[B_WREN]          = st.wren;
                    rd[B_SYNC]          = st.sync;
                    rd[B_HALF]          = st.half_second_status;
                    rd[B_OE]            = st.oe;
                    rd[B_PTR+1:B_PTR]   = st.ptr;
                end else if (paddr == OFF_VALH) begin
                    rd[7:0] = hi_byte;
                end else if (paddr == OFF_VALL) begin
                    rd[7:0] = lo_byte;
                end else if (paddr == OFF_IRQ_STAT) begin
                    rd[IRQ_W-1:0] = st.irq_status;
                end else if (paddr == OFF_IRQ_MASK) begin
                    rd[IRQ_W-1:0] = st.irq_mask;
                end else begin
                    next_st.pslverr = 1'b1;
                end
                // Writes return zero read data
                next_st.prdata = pwrite ? '0 : rd;
            end else begin
                next_st.pready  = 1'b0;
                next_st.pslverr = 1'b0;
            end
            // Access: writes and side effects take place here
            if (access_c) begin
                if (pwrite) begin
                    if (paddr == OFF_CTRL) begin
                        next_st.enable = pwdata[B_EN];
                        next_st.wren   = pwdata[B_WREN];
                        next_st.oe     = pwdata[B_OE];
                        next_st.ptr    = pwdata[B_PTR+1:B_PTR];
                    end else if (paddr == OFF_VALH || paddr == OFF_VALL) begin
                        load_value = pwdata[7:0];
                        if (!st.wren) begin
                            // Locked: value untouched, event flagged
                            irq_set[IRQ_LOCKED] = 1'b1;
                        end else if (paddr == OFF_VALL) begin
                            field_load[lo_idx] = 1'b1;
                        end else if (hi_valid) begin
                            field_load[hi_idx] = 1'b1;
                        end
                    end else if (paddr == OFF_IRQ_STAT) begin
                        irq_clr = pwdata[IRQ_W-1:0];
                    end else if (paddr == OFF_IRQ_MASK) begin
                        next_st.irq_mask = pwdata[IRQ_W-1:0];
                    end
                end
                // Only high value accesses walk the pointer down
                if (paddr == OFF_VALH && st.ptr != 2'h0) begin
                    next_st.ptr = st.ptr - 2'h1;
                end
            end
            irq_set[IRQ_TICK] = tick;
            // A new event wins over a same-cycle clear
            next_st.irq_status = (st.irq_status & ~irq_clr) | irq_set;
            next_st.irq        = |(next_st.irq_status & next_st.irq_mask);
            // Status flags follow the timebase position
            next_st.half_second_status = (next_st.presc >= PRESC_W'(SEC_CYCLES / 2));
            next_st.sync    = next_st.enable &&
                              (next_st.presc >= PRESC_W'(SEC_CYCLES - SYNC_LEAD_CYCLES));
            // Pin shows the half-second wave only when enabled
            next_st.clock_out      = next_st.oe && next_st.enable && next_st.half_second_status;
            next_st.clock_out_oe_n = !next_st.oe;
        end
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st                <= '0;
            st.ptr            <= PTR_RST;
            st.irq_mask       <= MASK_RST;
            st.clock_out_oe_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register
    assign prdata         = st.prdata;
    assign pready         = st.pready;
    assign pslverr        = st.pslverr;
    assign clock_out      = st.clock_out;
    assign clock_out_oe_n = st.clock_out_oe_n;
    assign irq            = st.irq;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    // All checks run on the system clock and rest during reset
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // Helpers for the checks below
    logic wr_vall; // Completing write to low value
    logic acc_valh; // Completing high value access
    assign wr_vall  = ce && access_c && pwrite && paddr == OFF_VALL;
    assign acc_valh = ce && access_c && paddr == OFF_VALH;

    AST_LOCKED_WRITE: assert property (
        wr_vall && !st.wren && !tick && st.ptr == WIN_SEC_MIN |=> $stable(fv[F_SEC]))
        else $error("locked write changed seconds");

    AST_WRITE_TAKES: assert property (
        wr_vall && st.wren && st.ptr == WIN_SEC_MIN |=> fv[F_SEC] == $past(pwdata[7:0]))
        else $error("enabled write not taken");

    AST_SYNC_AT_ROLL: assert property (
        tick |-> st.sync && st.presc == PRESC_W'(SEC_CYCLES - 1))
        else $error("rollover without sync flag");

    AST_HALF_RISE: assert property (
        $rose(st.half_second_status) |-> st.presc == PRESC_W'(SEC_CYCLES / 2))
        else $error("half-second flag rose at wrong count");

    AST_CLKOUT_OFF: assert property (
        !st.oe |-> !clock_out && clock_out_oe_n)
        else $error("clock output driven while disabled");

    AST_PTR_DEC: assert property (
        acc_valh && st.ptr != 2'h0 |=> st.ptr == $past(st.ptr) - 2'h1)
        else $error("pointer did not decrement");

    AST_PTR_FLOOR: assert property (
        acc_valh && st.ptr == 2'h0 |=> st.ptr == 2'h0)
        else $error("pointer went below zero");

    AST_PTR_LOW: assert property (
        ce && access_c && paddr == OFF_VALL |=> $stable(st.ptr))
        else $error("low value access moved pointer");

    AST_BIT14: assert property (
        pready && !pwrite && paddr == OFF_CTRL |-> !prdata[B_UNIMP])
        else $error("unimplemented bit read as one");

    AST_DISABLED: assert property (
        !st.enable && !field_load[F_SEC] |-> !tick ##1 $stable(fv[F_SEC]) || !$past(ce))
        else $error("clock ran while disabled");

    AST_HI_RESERVED: assert property (
        ce && setup_c && !pwrite && paddr == OFF_VALH && st.ptr == WIN_YEAR |=> prdata == '0)
        else $error("reserved slot read non-zero");

    AST_LO_YEAR: assert property (
        ce && setup_c && !pwrite && paddr == OFF_VALL && st.ptr == WIN_YEAR
        |=> prdata[7:0] == $past(fv[F_YEAR]))
        else $error("low byte not year");

    AST_SYNC_OFF: assert property (
        !st.enable |-> !st.sync)
        else $error("sync flag set while stopped");

    AST_HALF_FALL: assert property (
        $fell(st.half_second_status) |-> st.presc == '0)
        else $error("half-second flag fell mid-second");

    AST_OE_PIN: assert property (
        st.oe |-> !clock_out_oe_n)
        else $error("clock output not driven");

    AST_LOCKED_FLAG: assert property (
        ce && access_c && pwrite && !st.wren && (paddr == OFF_VALH || paddr == OFF_VALL)
        |=> st.irq_status[IRQ_LOCKED])
        else $error("locked write not flagged");

    AST_HI_MIN: assert property (
        ce && setup_c && !pwrite && paddr == OFF_VALH && st.ptr == WIN_SEC_MIN
        |=> prdata[7:0] == $past(fv[F_MIN]))
        else $error("high byte not minutes");

    AST_LO_SEC: assert property (
        ce && setup_c && !pwrite && paddr == OFF_VALL && st.ptr == WIN_SEC_MIN
        |=> prdata[7:0] == $past(fv[F_SEC]))
        else $error("low byte not seconds");

    // Main scenarios
    COV_TICK: cover property (tick);
    COV_WALK: cover property (acc_valh && st.ptr == 2'h2 ##[1:20] acc_valh && st.ptr == 2'h1);
    COV_LOCKED: cover property (wr_vall && !st.wren);
    COV_FREEZE: cover property (!ce && st.enable);
    COV_SYNC_READ: cover property (setup_c && paddr == OFF_VALL && st.sync);

endmodule // rtc_value_window

// [design/rtc_pkg.sv]
// Purpose: Shared constants for the clock/calendar value window block
// Assumes: APB with 32-bit data, byte addresses, 20 MHz system clock
// Notes:   Field counters are binary, one byte each
package rtc_pkg;

    // ----------------------------------------
    // Bus geometry and register offsets
    // ----------------------------------------
    localparam int          ADDR_W       = 8;      // APB address width
    localparam int          DATA_W       = 32;     // APB data width
    localparam logic [7:0]  OFF_CTRL     = 8'h00;  // rtc_config_calibration
    localparam logic [7:0]  OFF_VALH     = 8'h04;  // time_value_high
    localparam logic [7:0]  OFF_VALL     = 8'h08;  // time_value_low
    localparam logic [7:0]  OFF_IRQ_STAT = 8'h0c;  // Sticky event status
    localparam logic [7:0]  OFF_IRQ_MASK = 8'h10;  // Event mask

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int          B_EN         = 15;     // module_enable
    localparam int          B_UNIMP      = 14;     // Reads zero
    localparam int          B_WREN       = 13;     // value_write_enable
    localparam int          B_SYNC       = 12;     // read_sync_status
    localparam int          B_HALF       = 11;     // half_second_status
    localparam int          B_OE         = 10;     // clock_output_enable
    localparam int          B_PTR        = 8;      // value_window_pointer lsb
    localparam logic [1:0]  PTR_RST      = 2'h0;   // Pointer after reset
    localparam logic [1:0]  MASK_RST     = 2'h0;   // All events masked

    // ----------------------------------------
    // Window pointer codes
    // ----------------------------------------
    localparam logic [1:0]  WIN_SEC_MIN   = 2'h0;  // Minutes / seconds
    localparam logic [1:0]  WIN_HOUR_WDAY = 2'h1;  // Weekday / hours
    localparam logic [1:0]  WIN_DAY_MONTH = 2'h2;  // Month / day
    localparam logic [1:0]  WIN_YEAR      = 2'h3;  // Reserved / year

    // ----------------------------------------
    // Interrupt events
    // ----------------------------------------
    localparam int          IRQ_W        = 2;      // Number of events
    localparam int          IRQ_TICK     = 0;      // One second elapsed
    localparam int          IRQ_LOCKED   = 1;      // Value write refused

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int          CLK_HZ       = 20_000_000;            // System clock rate
    localparam int          SECOND_S     = 1;                     // Timebase period, s
    localparam int          SEC_CYCLES   = CLK_HZ * SECOND_S;     // Cycles per second
    localparam int          SYNC_LEAD_US = 10;                    // Sync flag lead, us
    localparam int          SYNC_LEAD_CYCLES = (SYNC_LEAD_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int          PRESC_W      = 25;                    // Prescaler width

    // ----------------------------------------
    // Time fields: index, range, carry source
    // ----------------------------------------
    localparam int          NFIELD = 7;
    localparam int          F_SEC = 0, F_MIN = 1, F_HOUR = 2, F_WDAY = 3;
    localparam int          F_DAY = 4, F_MONTH = 5, F_YEAR = 6;
    localparam logic [7:0]  FMIN [NFIELD] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    localparam logic [7:0]  FMAX [NFIELD] = '{8'h3b, 8'h3b, 8'h17, 8'h06, 8'h1f, 8'h0c, 8'h63};
    localparam int          FSRC [NFIELD] = '{0, 0, 1, 2, 2, 4, 5};

endpackage

// [design/field_counter.sv]
// Purpose: One wrapping time field with load
// Assumes: Load has priority over counting
// Notes:   Wraps from the top value to the bottom value
`timescale 1ns/10ps
module field_counter #(
    parameter logic [7:0] MIN_VAL = 8'h00,
    parameter logic [7:0] MAX_VAL = 8'h3b
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       ce,
    input  wire logic       carry_in,
    input  wire logic       load,
    input  wire logic [7:0] load_value,
    output logic      [7:0] value,
    output logic            carry_out
);

    typedef struct packed {
        logic [7:0] value;  // Field count
    } field_state_t;

    field_state_t st;       // Registered state
    field_state_t next_st;  // Next state

    // Carry leaves when the field wraps
    assign carry_out = carry_in && (st.value >= MAX_VAL);
    assign value     = st.value;

    // Next field value
    always_comb begin
        next_st = st;
        if (ce) begin
            if (load) begin
                next_st.value = load_value;
            end else if (carry_out) begin
                next_st.value = MIN_VAL;
            end else if (carry_in) begin
                next_st.value = st.value + 8'h01;
            end
        end
    end

    // State register
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st <= '{value: MIN_VAL};
        end else begin
            st <= next_st;
        end
    end

endmodule // field_counter

// [testbench/tb.sv]
// Purpose: Self-checking bench for the clock/calendar value window block
// Assumes: Second shortened to 100 cycles, sync lead of 4 cycles
// Notes:   Each scenario is a task that drives the APB port and judges the answers
`timescale 1ns/10ps
module tb;
    import rtc_pkg::*;
    // ----------------------------------------
    // Signals and counters
    // ----------------------------------------
    localparam int SECN = 100;                  // Shortened second
    logic        clk_sys    = 1'b0;             // System clock
    logic        reset_n    = 1'b0;             // Active-low reset
    logic        ce         = 1'b1;             // Clock enable, dropped in t_freeze
    logic        psel       = 1'b0;             // APB select
    logic        penable    = 1'b0;             // APB access phase
    logic        pwrite     = 1'b0;             // APB direction
    logic [7:0]  paddr      = 8'h00;            // APB byte address
    logic [31:0] pwdata     = 32'h0;            // APB write data
    logic [31:0] prdata;                        // APB read data
    logic        pready;                        // APB ready
    logic        pslverr;                       // APB error
    logic        clock_out;                     // Half-second square wave
    logic        clock_out_oe_n;                // Output enable, low drives
    logic        irq;                           // Level interrupt
    logic [31:0] rdat;                          // Last read data
    logic        serr;                          // Last error flag
    int          num_errors = 0;                // Mismatches
    int          n_compared = 0;                // Comparisons
    int          cycles     = 0;                // Timeout counter
    logic [7:0]  hi [4] = '{8'h15, 8'h04, 8'h0a, 8'h00}; // Upper fields by pointer
    logic [7:0]  lo [4] = '{8'h14, 8'h13, 8'h12, 8'h11}; // Lower fields by pointer

    rtc_value_window #(.SEC_CYCLES(SECN), .SYNC_LEAD_CYCLES(4)) uut (
        .clk_sys(clk_sys), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clock_out(clock_out), .clock_out_oe_n(clock_out_oe_n), .irq(irq));

    // ----------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------
    always #25 clk_sys = ~clk_sys;

    // Cut a hang short
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            stop_test();
        end
    end

    // Print counts and verdict, then end
    task automatic stop_test();
        $display("Compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Compare and report
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    // Count high cycles of the clock output
    task automatic count_hi(input int n, output int ones);
        ones = 0;
        repeat (n) begin
            @(posedge clk_sys);
            if (clock_out === 1'b1) ones++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Values after reset
    task automatic t_reset();
        apb(0, OFF_CTRL, 0);     chk("ctrl reset", rdat, 32'h0);
        apb(0, OFF_IRQ_MASK, 0); chk("mask reset", rdat, 32'h0);
        chk("oe_n reset", {31'h0, clock_out_oe_n}, 32'h1);
        chk("irq reset", {31'h0, irq}, 32'h0);
    endtask

    // Locked value writes, pointer moves, locked event interrupt
    task automatic t_locked();
        apb(1, OFF_CTRL, 32'h0100);
        apb(1, OFF_VALL, 32'h55);
        apb(0, OFF_VALL, 0);     chk("hours locked", rdat, 32'h0);
        apb(0, OFF_CTRL, 0);     chk("ptr after low", rdat, 32'h0100);
        apb(1, OFF_VALH, 32'h66);
        apb(0, OFF_CTRL, 0);     chk("ptr after high", rdat, 32'h0);
        apb(0, OFF_VALH, 0);     chk("minutes locked", rdat, 32'h0);
        apb(1, OFF_VALL, 32'h77);
        apb(0, OFF_VALL, 0);     chk("seconds locked", rdat, 32'h0);
        apb(0, OFF_IRQ_STAT, 0); chk("locked event", rdat, 32'h2);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1, OFF_IRQ_MASK, 32'h2);
        apb(0, OFF_IRQ_MASK, 0); chk("irq raised", {31'h0, irq}, 32'h1);
        apb(1, OFF_IRQ_STAT, 32'h2);
        apb(0, OFF_IRQ_STAT, 0); chk("status cleared", rdat, 32'h0);
        chk("irq cleared", {31'h0, irq}, 32'h0);
    endtask

    // Every pointer code written and read back in both halves
    task automatic t_window();
        apb(1, OFF_CTRL, 32'h7f00);
        apb(0, OFF_CTRL, 0);     chk("ctrl bit14 zero", rdat, 32'h2700);
        for (int i = 3; i >= 0; i--) begin
            apb(1, OFF_VALL, {24'h0, lo[i]});
            apb(1, OFF_VALH, {24'h0, hi[i]});
        end
        apb(0, OFF_CTRL, 0);     chk("ptr floor", rdat, 32'h2400);
        apb(1, OFF_CTRL, 32'h2300);
        for (int i = 3; i >= 0; i--) begin
            apb(0, OFF_VALL, 0); chk("lower field", rdat, {24'h0, lo[i]});
            apb(0, OFF_VALL, 0); chk("lower again", rdat, {24'h0, lo[i]});
            apb(0, OFF_VALH, 0); chk("upper field", rdat, {24'h0, hi[i]});
        end
        apb(0, OFF_CTRL, 0);     chk("ptr stays zero", rdat, 32'h2000);
    endtask

    // Running clock: output wave, flags, tick, stop when disabled
    task automatic t_run();
        int ones;
        int syncs;
        logic [31:0] s1;
        apb(1, OFF_CTRL, 32'h8400);
        count_hi(2, ones);
        count_hi(2 * SECN, ones);
        chk("wave high cycles", ones, SECN);
        chk("oe_n driving", {31'h0, clock_out_oe_n}, 32'h0);
        syncs = 0;
        for (int k = 0; k < 70; k++) begin
            apb(0, OFF_CTRL, 0);
            if (rdat[12] === 1'b1) begin
                syncs++;
                chk("sync in late half", rdat[11], 1'b1);
            end
        end
        chk("sync seen", syncs > 0, 1'b1);
        do begin
            apb(0, OFF_VALL, 0);
            s1 = rdat;
            apb(0, OFF_VALL, 0);
        end while (rdat !== s1);
        chk("seconds advanced", s1 != 32'h14, 1'b1);
        apb(0, OFF_IRQ_STAT, 0); chk("tick event", rdat[0], 1'b1);
        chk("tick masked", {31'h0, irq}, 32'h0);
        apb(1, OFF_IRQ_MASK, 32'h3);
        apb(0, OFF_IRQ_MASK, 0); chk("tick irq", {31'h0, irq}, 32'h1);
        apb(1, OFF_CTRL, 32'h8000);
        count_hi(2, ones);
        count_hi(2 * SECN, ones);
        chk("wave disabled", ones, 0);
        chk("oe_n released", {31'h0, clock_out_oe_n}, 32'h1);
        apb(1, OFF_CTRL, 32'h0000);
        apb(0, OFF_VALL, 0);
        s1 = rdat;
        repeat (3 * SECN) @(posedge clk_sys);
        apb(0, OFF_VALL, 0);     chk("stopped when disabled", rdat, s1);
    endtask

    // Clock enable low freezes the running clock and its wave
    task automatic t_freeze();
        int ones;
        logic v;
        logic [31:0] s1;
        apb(1, OFF_CTRL, 32'h8400);
        apb(0, OFF_VALL, 0);
        s1 = rdat;
        ce <= 1'b0;
        @(posedge clk_sys);
        v = clock_out;
        count_hi(2 * SECN, ones);
        chk("wave frozen", ones, v ? 2 * SECN : 0);
        ce <= 1'b1;
        apb(0, OFF_VALL, 0);
        chk("seconds frozen", (rdat + 60 - s1) % 60 < 2, 1'b1);
    endtask

    // Unmapped address answers with an error
    task automatic t_unmapped();
        apb(0, 8'h14, 0);
        chk("unmapped error", {31'h0, serr}, 32'h1);
        chk("unmapped data", rdat, 32'h0);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        t_reset();
        t_locked();
        t_window();
        t_run();
        t_freeze();
        t_unmapped();
        stop_test();
    end
endmodule // tb
